// *** design/bsc_pkg.sv ***
// Constants for the bias and system control register bank.
//
// Behaviour
// - Bias bit 7 picks half or twelfth level
// - Bias generator off when no pin selected
// - Bias bits 6..0 connect common, inputs five..zero
// - Any number of bias pins at once
// - Bias register resets to zero
// - System control at 09h, resets to 10h
// - Monitor 000 off, 001 shorts inputs mid-supply
// - Monitor 010 temperature sensor, host enables amplifier
// - Monitor 011/100 supply measurements force gain one
// - Monitor 101..111 burn-out 0.2, 1, 10 uA
// - Bits 4:3 select calibration averaging count
// - Bit 2 enables serial interface timeout
// - Bit 1 appends checksum byte
// - Bit 0 prepends status byte
package bsc_pkg;

  // ---------------------------------------------------------------------------
  // Register map.
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  BSC_SENSOR_BIAS_SELECT_IDX = 8'h08;
  localparam logic [7:0]  BSC_SYSTEM_CONTROL_IDX     = 8'h09;
  localparam logic [11:0] BSC_SENSOR_BIAS_SELECT_ADDR = 12'h020;
  localparam logic [11:0] BSC_SYSTEM_CONTROL_ADDR     = 12'h024;
  localparam logic [7:0]  BSC_SENSOR_BIAS_RESET      = 8'h00;
  localparam logic [7:0]  BSC_SYSTEM_CONTROL_RESET   = 8'h10;

  // ---------------------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------------------
  localparam int BSC_BIAS_LEVEL_BIT   = 7;
  localparam int BSC_BIAS_PINS_MSB    = 6;
  localparam int BSC_MONITOR_MSB      = 7;
  localparam int BSC_MONITOR_LSB      = 5;
  localparam int BSC_CAL_COUNT_MSB    = 4;
  localparam int BSC_CAL_COUNT_LSB    = 3;
  localparam int BSC_TIMEOUT_BIT      = 2;
  localparam int BSC_CHECKSUM_BIT     = 1;
  localparam int BSC_STATUS_BYTE_BIT  = 0;

  // ---------------------------------------------------------------------------
  // Monitor selections and calibration counts.
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    BSC_MON_OFF      = 3'b000,
    BSC_MON_SHORT    = 3'b001,
    BSC_MON_TEMP     = 3'b010,
    BSC_MON_ANALOG   = 3'b011,
    BSC_MON_DIGITAL  = 3'b100,
    BSC_MON_BURN_LO  = 3'b101,
    BSC_MON_BURN_MID = 3'b110,
    BSC_MON_BURN_HI  = 3'b111
  } bsc_monitor_e;

  localparam logic [4:0] BSC_CAL_ONE     = 5'h01;
  localparam logic [4:0] BSC_CAL_FOUR    = 5'h04;
  localparam logic [4:0] BSC_CAL_EIGHT   = 5'h08;
  localparam logic [4:0] BSC_CAL_SIXTEEN = 5'h10;

  localparam logic [1:0] BSC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] BSC_RESP_SLVERR = 2'b10;

endpackage

// *** design/bsc_byte_reg.sv ***
// One 8-bit software register with byte-lane write and reset value.
`timescale 1ns/10ps
module bsc_byte_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       write_en,
  input  wire logic [7:0] write_data,
  output logic      [7:0] value
);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value <= RESET_VALUE;
    end else if (write_en) begin
      value <= write_data;
    end
  end

endmodule

// *** design/bsc_regs.sv ***
// Sensor bias and system control register bank behind an AXI4-Lite slave.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module bsc_regs
  import bsc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             bias_level_select,
  output logic             bias_generator_enable,
  output logic             bias_to_common_input,
  output logic      [5:0]  bias_to_inputs,
  output logic      [2:0]  monitor_select,
  output logic             monitor_inputs_shorted,
  output logic             monitor_temperature,
  output logic             monitor_analog_supply,
  output logic             monitor_digital_supply,
  output logic             gain_forced_one,
  output logic      [2:0]  burnout_enable,
  output logic      [4:0]  calibration_average_count,
  output logic             timeout_enable,
  output logic             checksum_enable,
  output logic             status_byte_enable
);

  // ---------------------------------------------------------------------------
  // Write channel capture.
  // ---------------------------------------------------------------------------
  logic [11:0] aw_addr;
  logic        aw_held;
  logic [7:0]  w_data;
  logic        w_lane0;
  logic        w_held;
  logic [7:0]  sensor_bias_select;
  logic [7:0]  system_control;

  wire aw_take   = s_axi_awvalid && s_axi_awready;
  wire w_take    = s_axi_wvalid && s_axi_wready;
  wire do_write  = aw_held && w_held && !s_axi_bvalid;
  wire hit_bias  = (aw_addr == BSC_SENSOR_BIAS_SELECT_ADDR);
  wire hit_sys   = (aw_addr == BSC_SYSTEM_CONTROL_ADDR);
  wire wr_bias   = do_write && hit_bias && w_lane0;
  wire wr_sys    = do_write && hit_sys && w_lane0;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= {s_axi_awaddr[11:2], 2'b00};
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held  <= 1'b0;
      w_data  <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (w_take) begin
      w_held  <= 1'b1;
      w_data  <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= BSC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (hit_bias || hit_sys) ? BSC_RESP_OKAY : BSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Register storage.
  // ---------------------------------------------------------------------------
  // Both registers reset to their documented values and store whole bytes.
  bsc_byte_reg #(
    .RESET_VALUE (BSC_SENSOR_BIAS_RESET)
  ) u_bias_reg (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .write_en   (wr_bias),
    .write_data (w_data),
    .value      (sensor_bias_select)
  );

  bsc_byte_reg #(
    .RESET_VALUE (BSC_SYSTEM_CONTROL_RESET)
  ) u_sys_reg (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .write_en   (wr_sys),
    .write_data (w_data),
    .value      (system_control)
  );

  // ---------------------------------------------------------------------------
  // Read channel.
  // ---------------------------------------------------------------------------
  wire [11:0] rd_addr  = {s_axi_araddr[11:2], 2'b00};
  wire        rd_bias  = (rd_addr == BSC_SENSOR_BIAS_SELECT_ADDR);
  wire        rd_sys   = (rd_addr == BSC_SYSTEM_CONTROL_ADDR);
  wire        ar_take  = s_axi_arvalid && s_axi_arready;
  wire [7:0]  rd_byte  = rd_bias ? sensor_bias_select :
                         rd_sys  ? system_control : 8'h00;

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= BSC_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= (rd_bias || rd_sys) ? BSC_RESP_OKAY : BSC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Next register contents.
  // ---------------------------------------------------------------------------
  // The decoded outputs are flip-flops loaded from the value that each register
  // takes at the same edge, so they change together with the register.
  logic [7:0] next_bias;
  logic [7:0] next_sys;

  assign next_bias = !aresetn ? BSC_SENSOR_BIAS_RESET :
                     wr_bias  ? w_data : sensor_bias_select;
  assign next_sys  = !aresetn ? BSC_SYSTEM_CONTROL_RESET :
                     wr_sys   ? w_data : system_control;

  // ---------------------------------------------------------------------------
  // Bias control decode.
  // ---------------------------------------------------------------------------
  wire [6:0] next_pins      = next_bias[BSC_BIAS_PINS_MSB:0];
  wire       next_level_sel = next_bias[BSC_BIAS_LEVEL_BIT];
  wire       next_common    = next_pins[BSC_BIAS_PINS_MSB];
  wire [5:0] next_inputs    = next_pins[BSC_BIAS_PINS_MSB-1:0];
  wire       next_gen_en    = |next_pins;

  always_ff @(posedge aclk) begin
    bias_level_select     <= next_level_sel;
    bias_to_common_input  <= next_common;
    bias_to_inputs        <= next_inputs;
    bias_generator_enable <= next_gen_en;
  end

  // ---------------------------------------------------------------------------
  // System control decode.
  // ---------------------------------------------------------------------------
  bsc_monitor_e next_mon;
  logic [1:0]   next_cal_code;
  logic [4:0]   next_cal_count;

  assign next_mon      = bsc_monitor_e'(next_sys[BSC_MONITOR_MSB:BSC_MONITOR_LSB]);
  assign next_cal_code = next_sys[BSC_CAL_COUNT_MSB:BSC_CAL_COUNT_LSB];

  // At most one monitor function drives the analog side per code; code 000 drives none.
  wire       next_short    = (next_mon == BSC_MON_SHORT);
  wire       next_temp     = (next_mon == BSC_MON_TEMP);
  wire       next_analog   = (next_mon == BSC_MON_ANALOG);
  wire       next_digital  = (next_mon == BSC_MON_DIGITAL);
  wire       next_gain_one = next_analog || next_digital;
  wire [2:0] next_burnout  = {next_mon == BSC_MON_BURN_HI,
                              next_mon == BSC_MON_BURN_MID,
                              next_mon == BSC_MON_BURN_LO};

  assign next_cal_count = (next_cal_code == 2'b00) ? BSC_CAL_ONE  :
                          (next_cal_code == 2'b01) ? BSC_CAL_FOUR :
                          (next_cal_code == 2'b10) ? BSC_CAL_EIGHT :
                                                     BSC_CAL_SIXTEEN;

  wire next_timeout  = next_sys[BSC_TIMEOUT_BIT];
  wire next_checksum = next_sys[BSC_CHECKSUM_BIT];
  wire next_status   = next_sys[BSC_STATUS_BYTE_BIT];

  always_ff @(posedge aclk) begin
    monitor_select         <= next_mon;
    monitor_inputs_shorted <= next_short;
    monitor_temperature    <= next_temp;
    monitor_analog_supply  <= next_analog;
    monitor_digital_supply <= next_digital;
    gain_forced_one        <= next_gain_one;
    burnout_enable         <= next_burnout;
  end

  always_ff @(posedge aclk) begin
    calibration_average_count <= next_cal_count;
    timeout_enable            <= next_timeout;
    checksum_enable           <= next_checksum;
    status_byte_enable        <= next_status;
  end

endmodule

// *** dv/bsc_regs_sva.sv ***
// Checker for the bias and system control register bank.
`timescale 1ns/10ps
module bsc_regs_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        bias_level_select,
  input wire logic        bias_generator_enable,
  input wire logic        bias_to_common_input,
  input wire logic [5:0]  bias_to_inputs,
  input wire logic [2:0]  monitor_select,
  input wire logic        monitor_inputs_shorted,
  input wire logic        monitor_temperature,
  input wire logic        gain_forced_one,
  input wire logic [2:0]  burnout_enable,
  input wire logic [4:0]  calibration_average_count
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_RST_VALS: assert property ($rose(aresetn) |-> !bias_generator_enable && !bias_level_select
    && monitor_select == 3'h0 && calibration_average_count == 5'h08) else $error("Reset values wrong");
  AST_BIAS_EN: assert property (bias_generator_enable == (bias_to_common_input || |bias_to_inputs))
    else $error("Bias generator enable wrong");
  AST_SHORT: assert property (monitor_inputs_shorted == (monitor_select == 3'h1))
    else $error("Input short decode wrong");
  AST_TEMP: assert property (monitor_temperature == (monitor_select == 3'h2))
    else $error("Temperature decode wrong");
  AST_GAIN: assert property (gain_forced_one == (monitor_select inside {3'h3, 3'h4}))
    else $error("Forced gain decode wrong");
  AST_BURN: assert property (burnout_enable == {monitor_select == 3'h7, monitor_select == 3'h6,
    monitor_select == 3'h5}) else $error("Burn-out decode wrong");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data not held");
  AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("Read upper bits not zero");

  cover property (s_axi_rvalid && s_axi_rready);
  cover property (gain_forced_one);
  cover property (burnout_enable[2]);
endmodule

bind bsc_regs bsc_regs_sva u_bsc_regs_sva (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .bias_level_select, .bias_generator_enable, .bias_to_common_input, .bias_to_inputs,
  .monitor_select, .monitor_inputs_shorted, .monitor_temperature, .gain_forced_one, .burnout_enable,
  .calibration_average_count);

// *** dv/tb_bias_and_system_control_regs.sv ***
// Testbench for the bias and system control register bank.
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_bias_and_system_control_regs
  import bsc_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        bias_level_select, bias_generator_enable, bias_to_common_input, monitor_inputs_shorted;
  logic        monitor_temperature, monitor_analog_supply, monitor_digital_supply, gain_forced_one;
  logic        timeout_enable, checksum_enable, status_byte_enable;
  logic [5:0]  bias_to_inputs;
  logic [2:0]  monitor_select, burnout_enable, m;
  logic [4:0]  calibration_average_count;
  logic [7:0]  d;
  logic [4:0]  cal_tab [4] = '{BSC_CAL_ONE, BSC_CAL_FOUR, BSC_CAL_EIGHT, BSC_CAL_SIXTEEN};
  int          n_mismatch, compares;

  bsc_regs u_bsc_regs (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bias_level_select,
    .bias_generator_enable, .bias_to_common_input, .bias_to_inputs, .monitor_select, .monitor_inputs_shorted,
    .monitor_temperature, .monitor_analog_supply, .monitor_digital_supply, .gain_forced_one, .burnout_enable,
    .calibration_average_count, .timeout_enable, .checksum_enable, .status_byte_enable);

  // ---------------------------------------------------------------------------
  // Bus tasks and closing.
  // ---------------------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, r)
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, {24'h0, e})
    `CHK(s_axi_rresp, r)
  endtask

  task automatic end_of_test;
    $display("Mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  initial begin
    repeat (3000) @(posedge aclk);
    n_mismatch++;
    end_of_test;
  end

  // ---------------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------------
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    repeat (12) @(posedge aclk);
    `CHK({s_axi_awready, s_axi_wready, s_axi_arready}, 3'b111)
    aresetn <= 1'b1;
    rd(BSC_SENSOR_BIAS_SELECT_ADDR, BSC_SENSOR_BIAS_RESET, BSC_RESP_OKAY);
    rd(BSC_SYSTEM_CONTROL_ADDR, 8'h10, BSC_RESP_OKAY);
    `CHK(calibration_average_count, BSC_CAL_EIGHT)
    for (int j = 0; j < 9; j++) begin
      d = (j < 7) ? 8'h01 << j : ((j == 7) ? 8'h80 : 8'hFF);
      wr(BSC_SENSOR_BIAS_SELECT_ADDR, d, 4'hF, BSC_RESP_OKAY);
      `CHK({bias_to_common_input, bias_to_inputs}, d[6:0])
      `CHK(bias_generator_enable, |d[6:0])
      `CHK(bias_level_select, d[7])
      rd(BSC_SENSOR_BIAS_SELECT_ADDR, d, BSC_RESP_OKAY);
    end
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      d = {m, m[1:0], m};
      wr(BSC_SYSTEM_CONTROL_ADDR, d, 4'hF, BSC_RESP_OKAY);
      `CHK(monitor_select, m)
      `CHK({monitor_inputs_shorted, monitor_temperature, monitor_analog_supply, monitor_digital_supply,
        gain_forced_one}, {m == 1, m == 2, m == 3, m == 4, m == 3 || m == 4})
      `CHK(burnout_enable, {m == 7, m == 6, m == 5})
      `CHK(calibration_average_count, cal_tab[m[1:0]])
      `CHK({timeout_enable, checksum_enable, status_byte_enable}, m)
      rd(BSC_SYSTEM_CONTROL_ADDR, d, BSC_RESP_OKAY);
    end
    wr(BSC_SYSTEM_CONTROL_ADDR, 8'h00, 4'h0, BSC_RESP_OKAY);
    rd(BSC_SYSTEM_CONTROL_ADDR, 8'hFF, BSC_RESP_OKAY);
    wr(12'h028, 8'h55, 4'hF, BSC_RESP_SLVERR);
    rd(12'h028, 8'h00, BSC_RESP_SLVERR);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(BSC_SENSOR_BIAS_SELECT_ADDR, 8'h00, BSC_RESP_OKAY);
    rd(BSC_SYSTEM_CONTROL_ADDR, 8'h10, BSC_RESP_OKAY);
    end_of_test;
  end
endmodule
